// ==== ssc_pkg.sv ====
package ssc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_PORTS = 2;
  localparam int NUM_OFFS = 32;
  localparam int NUM_CNT = 64;
  localparam int NUM_DROP = 4;
  localparam int CNT_W = 30;
  localparam int DROP_W = 16;
  localparam int OCT_W = 11;
  localparam int IADDR_W = 10;

  // ----------------------------------------------------------------
  // Register port map
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_DATA_LOW = 4'h1;
  localparam logic [3:0] REG_DATA_HIGH = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_READ_BIT = 12;
  localparam int CTRL_SEL_HI = 11;
  localparam int CTRL_SEL_LO = 10;
  localparam logic [1:0] SEL_MIB = 2'h3;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Counter word and address layout
  // ----------------------------------------------------------------
  localparam int WORD_OVF_BIT = 31;
  localparam int WORD_VALID_BIT = 30;
  localparam logic [9:0] PORT0_BASE = 10'h000;
  localparam logic [9:0] PORT1_BASE = 10'h020;
  localparam logic [9:0] PORT_END = 10'h03f;
  localparam logic [9:0] DROP_TX0 = 10'h100;
  localparam logic [9:0] DROP_TX1 = 10'h101;
  localparam logic [9:0] DROP_RX0 = 10'h103;
  localparam logic [9:0] DROP_RX1 = 10'h104;
  localparam logic [4:0] OFF_RX_OCT = 5'h00;
  localparam logic [4:0] OFF_TX_OCT = 5'h14;
  // Offsets 0x01 and 0x15 never count
  localparam logic [31:0] LIVE_MASK = 32'hffdffffd;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_OFFS-1:0] hit;
    logic [OCT_W-1:0] rx_octets;
    logic [OCT_W-1:0] tx_octets;
  } ssc_port_evt_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } ssc_fsm_t;

  typedef struct packed {
    logic [15:0] ctrl;
    ssc_fsm_t fsm;
    logic [3:0] wait_cnt;
    logic [31:0] hold;
    logic [15:0] rdata;
    logic [NUM_CNT-1:0][CNT_W-1:0] cnt;
    logic [NUM_CNT-1:0] ovf;
    logic [NUM_DROP-1:0][DROP_W-1:0] drop;
  } ssc_state_t;

endpackage : ssc_pkg

// ==== ssc_counters.sv ====
`timescale 1ns/1ps
module ssc_counters #(
  parameter int READ_LAT = 2
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // Port events, one-cycle pulses, entry 0 is the first port
  input ssc_pkg::ssc_port_evt_t [ssc_pkg::NUM_PORTS-1:0] port_evt_i,
  // Drop events: tx first port, tx second, rx first, rx second
  input wire logic [ssc_pkg::NUM_DROP-1:0] drop_evt_i
);
  import ssc_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The wait counter is four bits wide
  if (READ_LAT < 1 || READ_LAT > 15)
  begin : g_bad_lat
    $error("READ_LAT must be 1 to 15");
  end

  localparam logic [3:0] LAT_LOAD = 4'(READ_LAT - 1);

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------
  // True for an address inside either per-port range
  function automatic logic is_port_addr(input logic [9:0] a);
    is_port_addr = (a >= PORT0_BASE) && (a <= PORT_END);
  endfunction : is_port_addr

  // Slot of a drop counter, or 3'h4 when the address holds none
  function automatic logic [2:0] drop_slot(input logic [9:0] a);
    case (a)
      DROP_TX0: drop_slot = 3'h0;
      DROP_TX1: drop_slot = 3'h1;
      DROP_RX0: drop_slot = 3'h2;
      DROP_RX1: drop_slot = 3'h3;
      default: drop_slot = 3'h4;
    endcase
  endfunction : drop_slot

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ssc_state_t s;
  ssc_state_t next_s;

  // Next-state logic: command engine, counting, register reads
  always_comb
  begin
    logic clr_en;
    logic [5:0] clr_idx;
    logic [9:0] ia;
    logic [2:0] ds;
    logic [4:0] off;
    logic [CNT_W-1:0] inc;
    logic [CNT_W-1:0] base;
    logic [CNT_W:0] sum;
    logic ovf_base;
    ssc_port_evt_t ev;
    clr_en = 1'b0;
    clr_idx = 6'h00;
    ia = s.ctrl[IADDR_W-1:0];
    ds = drop_slot(ia);
    off = 5'h00;
    inc = '0;
    base = '0;
    sum = '0;
    ovf_base = 1'b0;
    ev = '0;
    next_s = s;
    next_s.rdata = 16'h0000;

    // Command engine: wait, then snapshot the addressed counter
    case (s.fsm)
      ST_IDLE:
      begin
        next_s.fsm = ST_IDLE;
      end
      ST_WAIT:
      begin
        if (s.wait_cnt == 4'h0)
        begin
          next_s.fsm = ST_DONE;
          if (is_port_addr(ia))
          begin
            clr_idx = ia[5:0];
            clr_en = 1'b1;
            next_s.hold = {s.ovf[clr_idx], 1'b1, s.cnt[clr_idx]};
          end
          else if (ds != 3'h4)
          begin
            // Flags stay zero; value is left in place
            next_s.hold = {16'h0000, s.drop[ds[1:0]]};
          end
          else
          begin
            next_s.hold = 32'h0000_0000;
          end
        end
        else
        begin
          next_s.wait_cnt = s.wait_cnt - 4'h1;
        end
      end
      ST_DONE:
      begin
        next_s.fsm = ST_DONE;
      end
      default:
      begin
        next_s.fsm = ST_IDLE;
      end
    endcase

    // A command write restarts the engine even mid-wait
    if (wr_i && addr_i == REG_CTRL)
    begin
      next_s.ctrl = wdata_i;
      if (wdata_i[CTRL_READ_BIT] &&
          wdata_i[CTRL_SEL_HI:CTRL_SEL_LO] == SEL_MIB)
      begin
        next_s.fsm = ST_WAIT;
        next_s.wait_cnt = LAT_LOAD;
        // Clearing the hold makes the valid flag read zero
        next_s.hold = 32'h0000_0000;
      end
    end

    // Per-port counters; an event in the clearing cycle is kept
    for (int i = 0; i < NUM_CNT; i++)
    begin
      off = 5'(i);
      ev = port_evt_i[i / NUM_OFFS];
      if (!(ev.hit[off] && LIVE_MASK[off]))
      begin
        inc = '0;
      end
      else if (off == OFF_RX_OCT)
      begin
        inc = CNT_W'(ev.rx_octets);
      end
      else if (off == OFF_TX_OCT)
      begin
        inc = CNT_W'(ev.tx_octets);
      end
      else
      begin
        inc = CNT_W'(1);
      end
      if (clr_en && clr_idx == 6'(i))
      begin
        base = '0;
        ovf_base = 1'b0;
      end
      else
      begin
        base = s.cnt[i];
        ovf_base = s.ovf[i];
      end
      sum = {1'b0, base} + {1'b0, inc};
      next_s.cnt[i] = sum[CNT_W-1:0];
      next_s.ovf[i] = ovf_base | sum[CNT_W];
    end

    // Drop counters wrap silently; host tracks overflow
    for (int k = 0; k < NUM_DROP; k++)
    begin
      if (drop_evt_i[k])
      begin
        next_s.drop[k] = s.drop[k] + 16'h0001;
      end
    end

    // Read data for the cycle after the strobe, zero otherwise
    if (rd_i)
    begin
      case (addr_i)
        REG_CTRL: next_s.rdata = s.ctrl;
        REG_DATA_LOW: next_s.rdata = s.hold[15:0];
        REG_DATA_HIGH: next_s.rdata = s.hold[31:16];
        REG_STATUS: next_s.rdata = {13'h0, s.fsm};
        default: next_s.rdata = 16'h0000;
      endcase
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      s <= '0;
      s.ctrl <= CTRL_RESET;
      s.fsm <= ST_IDLE;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Read data leaves straight from its flip-flops
  assign rdata_o = s.rdata;

endmodule : ssc_counters

// ==== ssc_counters_chk.sv ====
`timescale 1ns/1ps
module ssc_chk #(
  parameter int READ_LAT = 2
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  // Events
  input ssc_pkg::ssc_port_evt_t [ssc_pkg::NUM_PORTS-1:0] port_evt_i,
  input wire logic [ssc_pkg::NUM_DROP-1:0] drop_evt_i
);
  import ssc_pkg::*;
  // Read command start and high word read
  wire start = wr_i && addr_i == REG_CTRL && wdata_i[CTRL_READ_BIT]
    && wdata_i[CTRL_SEL_HI:CTRL_SEL_LO] == SEL_MIB;
  wire rdh = rd_i && addr_i == REG_DATA_HIGH;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0)
    else $error("read data not zero outside answer");
  a_unmapped_rd: assert property (
    $past(rd_i) && $past(addr_i) > REG_STATUS |-> rdata_o == 16'h0)
    else $error("unmapped register read not zero");
  a_status_code: assert property ($past(rd_i && addr_i == REG_STATUS)
    |-> $onehot(rdata_o[2:0]) && rdata_o[15:3] == 13'h0)
    else $error("bad status code");
  a_cmd_invalid: assert property (start ##1 rdh |=> !rdata_o[14])
    else $error("valid set before capture");
  a_status_wait: assert property (
    start ##1 (rd_i && addr_i == REG_STATUS) |=> rdata_o == 16'h0002)
    else $error("engine not waiting");
  a_port_valid: assert property (
    start && wdata_i[9:6] == 4'h0 ##1 rdh ##1 !wr_i ##1 rdh
    |=> rdata_o[14]) else $error("valid missing");
  a_drop_flags: assert property (
    start && wdata_i[8] ##1 rdh ##1 !wr_i ##1 rdh |=> rdata_o == 16'h0)
    else $error("drop word flags");
  a_hold_stable: assert property (
    rdh ##1 (rdata_o[14] && !wr_i) ##1 rdh
    |=> rdata_o == $past(rdata_o, 2))
    else $error("held word moved");
  // Main scenarios
  c_start: cover property (start);
  c_valid: cover property (rdh ##1 rdata_o[14]);
  c_drop: cover property (|drop_evt_i);
endmodule : ssc_chk

bind ssc_counters ssc_chk #(.READ_LAT(READ_LAT)) ssc_chk_i (
  .clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .port_evt_i(port_evt_i),
  .drop_evt_i(drop_evt_i));

// ==== ssc_host.sv ====
`timescale 1ns/1ps
module ssc_host (
  // Clock and read data
  input wire logic clock_i,
  input wire logic [15:0] rdata_i,
  // Register port drive
  output logic [3:0] addr_o,
  output logic [15:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  import ssc_pkg::*;
  // Bus idle from time zero
  initial
  begin
    {addr_o, wdata_o, wr_o, rd_o} = '0;
  end
  // Read strobe for one cycle; data stands only in the next cycle
  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    @(posedge clock_i);
    {rd_o, addr_o} <= {1'b1, a};
    @(posedge clock_i);
    rd_o <= 1'b0;
    #1 q = rdata_i;
  endtask : rd
  // Command write, then a read with no gap
  task automatic wr_rd(input logic [15:0] d, input logic [3:0] a,
                       output logic [15:0] q);
    @(posedge clock_i);
    {wr_o, addr_o, wdata_o} <= {1'b1, REG_CTRL, d};
    @(posedge clock_i);
    {wr_o, rd_o, addr_o} <= {1'b0, 1'b1, a};
    @(posedge clock_i);
    rd_o <= 1'b0;
    #1 q = rdata_i;
  endtask : wr_rd
  // Poll is bounded so a stuck valid flag cannot hang the host
  task automatic fetch(input logic [9:0] ia, output logic [31:0] w);
    int n;
    n = 0;
    wr_rd({6'h07, ia}, REG_DATA_HIGH, w[31:16]);
    while (!w[30] && !ia[8] && n < 8)
    begin
      rd(REG_DATA_HIGH, w[31:16]);
      n++;
    end
    rd(REG_DATA_HIGH, w[31:16]);
    rd(REG_DATA_LOW, w[15:0]);
  endtask : fetch
endmodule : ssc_host

// ==== ssc_counters_test.sv ====
`timescale 1ns/1ps
module ssc_counters_test;
  import ssc_pkg::*;
  logic clock_i, rstn_i, wr_i, rd_i;
  logic [3:0] addr_i;
  logic [15:0] wdata_i, rdata_o;
  ssc_port_evt_t [NUM_PORTS-1:0] port_evt_i;
  logic [NUM_DROP-1:0] drop_evt_i;
  logic [31:0] w;
  int err_count = 0, comparisons = 0, cyc = 0;
  logic [9:0] drops [4] = '{DROP_TX0, DROP_TX1, DROP_RX0, DROP_RX1};
  ssc_counters ssc_counters_i (.clock_i(clock_i), .rstn_i(rstn_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .port_evt_i(port_evt_i), .drop_evt_i(drop_evt_i));
  ssc_host ssc_host_i (.clock_i(clock_i), .rdata_i(rdata_o),
    .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
  // Clock, 100 ns period
  initial
  begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  // Hang guard, well above the run length
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      err_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("Errors %0d of %0d checks", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic cmp(input string n, input logic [31:0] e, s);
    comparisons++;
    if (s !== e)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  // One event pulse on both ports, octets 7 rx and 9 tx
  task automatic pulse(input logic [31:0] h, input logic [3:0] d);
    @(posedge clock_i);
    port_evt_i <= {2{h, 11'h7, 11'h9}};
    drop_evt_i <= d;
    @(posedge clock_i);
    port_evt_i <= '0;
    drop_evt_i <= '0;
  endtask : pulse
  // Every port counter; k low expects all cleared by the last sweep
  task automatic sweep(input logic k);
    logic [31:0] e;
    for (int i = 0; i < NUM_CNT; i++)
    begin
      e = 32'h0;
      if (k && LIVE_MASK[i % 32])
        e = (i % 32 == 0) ? 32'h7 : (i % 32 == 20) ? 32'h9 : 32'h1;
      e[WORD_VALID_BIT] = 1'b1;
      ssc_host_i.fetch(i[9:0], w);
      cmp("port counter", e, w);
    end
  endtask : sweep
  // Main sequence
  initial
  begin
    rstn_i = 1'b0;
    port_evt_i = '0;
    drop_evt_i = '0;
    repeat (10) @(posedge clock_i);
    rstn_i <= 1'b1;
    pulse(32'hffffffff, 4'hf);
    pulse(32'h0, 4'hf);
    sweep(1'b1);
    sweep(1'b0);
    for (int j = 0; j < 8; j++)
    begin
      ssc_host_i.fetch(drops[j % 4], w);
      cmp("drop counter", 32'h2, w);
    end
    ssc_host_i.fetch(10'h080, w);
    cmp("unmapped word", 32'h0, w);
    ssc_host_i.wr_rd(16'h1c0e, REG_STATUS, w[15:0]);
    cmp("status wait", 32'h2, {16'h0, w[15:0]});
    ssc_host_i.rd(4'h9, w[15:0]);
    cmp("unmapped reg", 32'h0, {16'h0, w[15:0]});
    // Mid-run reset must clear drop counters, control and engine
    pulse(32'h0, 4'hf);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rstn_i <= 1'b1;
    ssc_host_i.rd(REG_STATUS, w[15:0]);
    cmp("status idle", 32'h1, {16'h0, w[15:0]});
    // Control write without the read bit stores but does not start
    ssc_host_i.wr_rd(16'h0c05, REG_CTRL, w[15:0]);
    cmp("control store", 32'h0c05, {16'h0, w[15:0]});
    ssc_host_i.rd(REG_STATUS, w[15:0]);
    cmp("no start", 32'h1, {16'h0, w[15:0]});
    ssc_host_i.fetch(DROP_TX0, w);
    cmp("drop after reset", 32'h0, w);
    close_out();
  end
endmodule : ssc_counters_test
